// ==== hdl/qesc_top.sv ====
`timescale 1ns/1ps

module qesc_top
    import qesc_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF,
    parameter int CNT_W  = CNT_W_DEF
) (
    input  wire logic              SYS_CLK,
    input  wire logic              NRST,
    input  wire logic              COUNTER_INPUT_ZERO,
    input  wire logic              COUNTER_INPUT_ONE,
    input  wire logic              COUNTER_INPUT_TWO,
    input  wire logic              COUNTER_INPUT_THREE,
    input  wire logic              SCAN_BEGIN_EVENT,
    input  wire logic              ACQ_BEGIN,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WR_DATA,
    input  wire logic              WR_STB,
    input  wire logic              RD_STB,
    output logic      [DATA_W-1:0] RD_DATA,
    output logic      [NUM_CH-1:0] INDEX_FOUND
);

    // ********************************************************************
    // Elaboration checks
    // ********************************************************************
    if (NUM_CH != 4) begin : g_chk_ch
        $error("qesc_top: channel pairing and 2-bit map select need 4 channels");
    end
    if (CNT_W != 16) begin : g_chk_w
        $error("qesc_top: counters are 16 bits wide");
    end
    if (DATA_W < CNT_W || DATA_W < $bits(qesc_cfg_t)) begin : g_chk_d
        $error("qesc_top: read word narrower than a counter or config");
    end

    // ********************************************************************
    // Input synchronisers and debounce
    // ********************************************************************
    // Raw pins, two-stage line, filtered level and its last value
    logic [NUM_CH-1:0] sync_meta;
    logic [NUM_CH-1:0] sync_line;
    logic [NUM_CH-1:0] filt;
    logic [NUM_CH-1:0] filt_prev;
    wire  [NUM_CH-1:0] raw_in = {COUNTER_INPUT_THREE, COUNTER_INPUT_TWO,
                                 COUNTER_INPUT_ONE, COUNTER_INPUT_ZERO};
    // Edges of the filtered level, one cycle wide each
    wire  [NUM_CH-1:0] rise   = filt & ~filt_prev;
    wire  [NUM_CH-1:0] fall   = ~filt & filt_prev;

    // Two stages, then edges taken only from the filtered level
    // Pins count as synchronous, yet two stages still guard against skew
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            sync_meta <= '0;
            sync_line <= '0;
            filt_prev <= '0;
        end else begin
            sync_meta <= raw_in;
            sync_line <= sync_meta;
            filt_prev <= filt;
        end
    end

    // ********************************************************************
    // Tick dividers for period mode
    // ********************************************************************
    // One enable per tick size, and a divider for each slower one
    logic [3:0]          tick_pulse;
    logic [TICK_DIV_W-1:0] tick_cnt [3];
    localparam int TICK_CYC [3] = '{TICK1_CYC, TICK2_CYC, TICK3_CYC};

    // Finest tick is every clock; slower ones are one-cycle enables
    assign tick_pulse[0] = 1'b1;

    for (genvar t = 0; t < 3; t++) begin : g_tick
        localparam logic [TICK_DIV_W-1:0] TLAST = TICK_DIV_W'(TICK_CYC[t] - 1);

        // A tick longer than the divider could count would wrap early
        if (TICK_CYC[t] > (1 << TICK_DIV_W)) begin : g_chk_div
            $error("qesc_top: tick divider too narrow");
        end

        // Wrap marks one tick of this rate
        wire wrap = (tick_cnt[t] == TLAST);

        assign tick_pulse[t+1] = wrap;

        // Free-running divider, restarted at acquisition start for a clean phase
        always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
                tick_cnt[t] <= '0;
            end else if (ACQ_BEGIN || wrap) begin
                tick_cnt[t] <= '0;
            end else begin
                tick_cnt[t] <= tick_cnt[t] + 1'b1;
            end
        end
    end

    // ********************************************************************
    // Register decode
    // ********************************************************************
    // Word-aligned hits only; a misaligned address reads as unmapped
    wire       hit_cfg  = (ADDR[7:4] == PAGE_CFG) && (ADDR[1:0] == 2'h0);
    wire       hit_cap  = (ADDR[7:4] == PAGE_CAP) && (ADDR[1:0] == 2'h0);
    wire       hit_stat = (ADDR == OFS_STATUS);
    wire [1:0] reg_idx  = ADDR[3:2];

    // Per-channel words gathered for the read path
    qesc_cfg_t         cfg_word [NUM_CH];
    logic [CNT_W-1:0]  cap_word [NUM_CH];
    logic [NUM_CH-1:0] index_seen;

    // ********************************************************************
    // Per-channel counter logic
    // ********************************************************************
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        localparam int PB = ch | 1;  // Partner B channel of an even A channel
        // Channel state
        qesc_cfg_t        cfg;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] pcnt;
        logic [CNT_W-1:0] pval;
        logic [CNT_W-1:0] hold;
        logic             seen;
        logic             p_armed;

        // Debounce per channel, selectable independently
        // A longer interval also delays genuine edges by the same time
        qesc_debounce #(
            .CW (DEB_CNT_W)
        ) u_deb (
            .clk   (SYS_CLK),
            .rst_n (NRST),
            .din   (sync_line[ch]),
            .sel   (cfg.deb_sel),
            .dout  (filt[ch])
        );

        // Mapped channel conditions
        wire map_lvl  = filt[cfg.map_sel];
        wire map_rise = rise[cfg.map_sel];
        wire gate_ok  = !cfg.mapped_gate_option || map_lvl;
        wire clr_evt  = cfg.mapped_clear_option && map_rise;

        // Quadrature decode, only an even channel pairs with its odd neighbour
        wire is_enc   = (cfg.mode == QESC_ENCODER) && ((ch & 1) == 0);
        wire a_lvl    = filt[ch];
        wire b_lvl    = filt[PB];
        wire a_edge   = rise[ch] | fall[ch];
        wire b_edge   = rise[PB] | fall[PB];
        // A leads B: A moves to differ from B, or B moves to equal A
        wire a_up     = a_edge && (a_lvl != b_lvl);
        wire b_up     = b_edge && (a_lvl == b_lvl);
        // Resolution picks which edges may move the count
        wire res1     = (cfg.quadrature_resolution_select == RES_1X);
        wire res2     = (cfg.quadrature_resolution_select == RES_2X);
        wire a_use    = res1 ? rise[ch] : a_edge;
        wire b_use    = (res1 || res2) ? 1'b0 : b_edge;
        wire step_up  = (a_use && a_up) || (b_use && b_up);
        wire step_dn  = (a_use && !a_up) || (b_use && !b_up);
        // With B edges in use (4x), simultaneous A and B moves cancel out instead of double counting
        wire step_en  = gate_ok && (step_up != step_dn);

        // Totalize saturates at full scale instead of wrapping
        wire at_top   = (cnt == {CNT_W{1'b1}});
        wire tot_en   = (cfg.mode == QESC_TOTALIZE) && rise[ch] && gate_ok && !at_top;

        // Encoder wraps in either direction
        wire [CNT_W-1:0] enc_step = step_up ? cnt + 1'b1 : cnt - 1'b1;

        wire [CNT_W-1:0] next_cnt =
            (is_enc && clr_evt)  ? '0 :
            (is_enc && step_en)  ? enc_step :
            tot_en               ? cnt + 1'b1 :
            cnt;

        // Period: ungated tick counter, restarted on each own rising edge
        wire p_mode   = (cfg.mode == QESC_PERIOD);
        wire p_top    = (pcnt == {CNT_W{1'b1}});
        wire p_tick   = tick_pulse[cfg.tick_sel] && !p_top;
        // The tick at the closing edge belongs to the period it closes
        wire [CNT_W-1:0] next_pcnt = p_tick ? pcnt + 1'b1 : pcnt;

        // Value handed to the scan for this channel
        wire [CNT_W-1:0] live = p_mode ? pval : cnt;

        // Configuration register
        // Only the low field bits are kept; the rest read back as zero
        always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
                cfg <= qesc_cfg_t'(CFG_RESET);
            end else if (WR_STB && hit_cfg && reg_idx == 2'(ch)) begin
                cfg <= qesc_cfg_t'(WR_DATA[$bits(qesc_cfg_t)-1:0]);
            end
        end

        // Position or totalize count
        always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
                cnt <= '0;
            end else if (ACQ_BEGIN) begin
                cnt <= '0;
            end else begin
                cnt <= next_cnt;
            end
        end

        // Single-period measurement; the stretch from acquisition start to the
        // first own edge is no whole period, so that edge only arms the channel
        always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
                pcnt    <= '0;
                pval    <= '0;
                p_armed <= 1'b0;
            end else if (ACQ_BEGIN) begin
                pcnt    <= '0;
                pval    <= '0;
                p_armed <= 1'b0;
            end else if (p_mode && rise[ch]) begin
                pval    <= p_armed ? next_pcnt : pval;
                pcnt    <= '0;
                p_armed <= 1'b1;
            end else if (p_mode && p_tick) begin
                pcnt <= next_pcnt;
            end
        end

        // Scan capture: data moves only on scan boundaries, one scan behind
        // A start of acquisition in the same cycle beats the scan
        always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
                hold <= '0;
            end else if (ACQ_BEGIN) begin
                hold <= '0;
            end else if (SCAN_BEGIN_EVENT) begin
                hold <= live;
            end
        end

        // Index reference found; a same-cycle index beats the restart
        // Only an encoder channel with the clear option can find the index
        always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
                seen <= 1'b0;
            end else begin
                seen <= (seen && !ACQ_BEGIN) || (is_enc && clr_evt);
            end
        end

        // Hand the channel words to the read path
        assign cfg_word[ch]   = cfg;
        assign cap_word[ch]   = hold;
        assign index_seen[ch] = seen;
    end

    // ********************************************************************
    // Read path
    // ********************************************************************
    // Capture words are plain registers; reading them stalls nothing
    wire [DATA_W-1:0] rd_cfg  = DATA_W'(cfg_word[reg_idx]);
    wire [DATA_W-1:0] rd_cap  = DATA_W'(cap_word[reg_idx]);
    wire [DATA_W-1:0] rd_stat = DATA_W'(index_seen);
    // The three hits never overlap, so the order is moot
    wire [DATA_W-1:0] rd_word = hit_cfg  ? rd_cfg  :
                                hit_cap  ? rd_cap  :
                                hit_stat ? rd_stat :
                                {DATA_W{1'b0}};

    // Read data stand in each cycle after a cycle with the strobe high, zero otherwise
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            RD_DATA <= '0;
        end else begin
            RD_DATA <= RD_STB ? rd_word : {DATA_W{1'b0}};
        end
    end

    // Index flags mirrored on pins for the sequencer
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            INDEX_FOUND <= '0;
        end else begin
            INDEX_FOUND <= index_seen;
        end
    end

endmodule

// ==== hdl/qesc_pkg.sv ====
package qesc_pkg;

    // ********************************************************************
    // Geometry
    // ********************************************************************
    localparam int NUM_CH_DEF  = 4;
    localparam int CNT_W_DEF   = 16;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    localparam int DEB_CNT_W   = 10;

    // ********************************************************************
    // Register offsets (byte addresses, one word each)
    // ********************************************************************
    localparam logic [7:0] OFS_CFG_BASE = 8'h00;  // Channel n config at 0x00 + 4n
    localparam logic [7:0] OFS_CAP_BASE = 8'h10;  // Channel n capture at 0x10 + 4n
    localparam logic [7:0] OFS_STATUS   = 8'h20;  // Index-seen flags
    localparam logic [3:0] PAGE_CFG     = 4'h0;
    localparam logic [3:0] PAGE_CAP     = 4'h1;

    // ********************************************************************
    // Modes and field encodings
    // ********************************************************************
    typedef enum logic [1:0] {
        QESC_TOTALIZE,
        QESC_ENCODER,
        QESC_PERIOD,
        QESC_IDLE
    } qesc_mode_t;

    localparam logic [1:0] RES_1X = 2'h0;  // Rising edges of A
    localparam logic [1:0] RES_2X = 2'h1;  // Both edges of A
    localparam logic [1:0] RES_4X = 2'h2;  // Both edges of A and B (code 3 alike)

    // Per-channel configuration word, low bits of the config register
    typedef struct packed {
        logic [2:0] deb_sel;                       // bits 12:10, 0 = no filter
        logic [1:0] tick_sel;                      // bits 9:8
        logic       mapped_clear_option;           // bit 7
        logic       mapped_gate_option;            // bit 6
        logic [1:0] map_sel;                       // bits 5:4
        logic [1:0] quadrature_resolution_select;  // bits 3:2
        qesc_mode_t mode;                          // bits 1:0
    } qesc_cfg_t;

    localparam logic [12:0] CFG_RESET = 13'h0000;

    // ********************************************************************
    // Timing: tick sizes in tenths of a nanosecond, clock 50 ns
    // ********************************************************************
    localparam int CLK_PERIOD_TENTHS = 500;
    localparam int TICK1_TENTHS      = 2083;    // 208.3 ns
    localparam int TICK2_TENTHS      = 20833;   // 2083.3 ns
    localparam int TICK3_TENTHS      = 208330;  // 20833 ns
    localparam int TICK1_CYC = (TICK1_TENTHS / CLK_PERIOD_TENTHS < 1) ? 1
                             : TICK1_TENTHS / CLK_PERIOD_TENTHS;
    localparam int TICK2_CYC = (TICK2_TENTHS / CLK_PERIOD_TENTHS < 1) ? 1
                             : TICK2_TENTHS / CLK_PERIOD_TENTHS;
    localparam int TICK3_CYC = (TICK3_TENTHS / CLK_PERIOD_TENTHS < 1) ? 1
                             : TICK3_TENTHS / CLK_PERIOD_TENTHS;
    localparam int TICK_DIV_W = 10;

    // Debounce: stable time is 2^(sel + DEB_LOG_BASE) cycles for sel > 0
    localparam int DEB_LOG_BASE = 1;

endpackage

// ==== hdl/qesc_debounce.sv ====
`timescale 1ns/1ps

// ************************************************************************
// Single-input debounce filter
// ************************************************************************
module qesc_debounce
    import qesc_pkg::*;
#(
    parameter int CW = DEB_CNT_W
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       din,
    input  wire logic [2:0] sel,
    output logic            dout
);

    logic [CW-1:0] cnt;
    logic [CW-1:0] limit;
    wire           differs = (din != dout);
    wire           settled = (cnt == limit);

    if (CW < 10) begin : g_chk
        $error("qesc_debounce: counter too narrow for longest interval");
    end

    // Stable time grows by powers of two with the select
    assign limit = CW'((1 << (32'(sel) + DEB_LOG_BASE)) - 1);

    // Output follows only after the input has held its new level long enough
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= '0;
            dout <= 1'b0;
        end else if (!differs) begin
            cnt <= '0;
        end else if (sel == 3'h0 || settled) begin
            cnt  <= '0;
            dout <= din;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

endmodule

// ==== verif/qesc_enc_model.sv ====
`timescale 1ns/1ps

// ********************************************************************
// Quadrature shaft encoder seen from the counter pins
// ********************************************************************
module qesc_enc_model (
    input  wire logic clk,
    input  wire logic step,
    input  wire logic dir_up,
    input  wire logic mark,
    input  wire logic glitch,
    output logic      pha,
    output logic      phb,
    output logic      idx
);
    logic [1:0] pos = 2'h0;

    // Gray walk: only one phase moves per step, so no step is ambiguous
    always_ff @(posedge clk) begin
        if (step) begin
            pos <= dir_up ? pos + 2'h1 : pos - 2'h1;
        end
    end

    // Glitch only when a scenario asks for vibration on phase A
    assign pha = (pos[1] ^ pos[0]) ^ glitch;
    assign phb = pos[1];
    assign idx = mark;
endmodule

// ==== verif/qesc_top_properties.sv ====
`timescale 1ns/1ps

// ********************************************************************
// Port checks for the scan counter block
// ********************************************************************
module qesc_top_props
    import qesc_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF,
    parameter int CNT_W  = CNT_W_DEF
) (
    input wire logic              SYS_CLK,
    input wire logic              NRST,
    input wire logic              COUNTER_INPUT_ZERO,
    input wire logic              COUNTER_INPUT_ONE,
    input wire logic              COUNTER_INPUT_TWO,
    input wire logic              COUNTER_INPUT_THREE,
    input wire logic              SCAN_BEGIN_EVENT,
    input wire logic              ACQ_BEGIN,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WR_DATA,
    input wire logic              WR_STB,
    input wire logic              RD_STB,
    input wire logic [DATA_W-1:0] RD_DATA,
    input wire logic [NUM_CH-1:0] INDEX_FOUND
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);

    // Read data live in each cycle after a strobe cycle, zero otherwise
    a_rd_idle_zero: assert property (!$past(RD_STB) |-> RD_DATA == '0)
        else $error("read data not zero outside read slot");
    a_unmapped_zero: assert property ($past(RD_STB) && ($past(ADDR) > OFS_STATUS
        || $past(ADDR[1:0]) != 2'h0) |-> RD_DATA == '0)
        else $error("unmapped read returned data");
    a_cap_upper_zero: assert property ($past(RD_STB) && $past(ADDR[7:4]) == PAGE_CAP
        |-> RD_DATA[31:16] == '0)
        else $error("capture wider than 16 bits");
    a_status_mirror: assert property ($past(RD_STB) && $past(ADDR) == OFS_STATUS
        |-> RD_DATA == DATA_W'(INDEX_FOUND))
        else $error("status read differs from index flags");
    a_acq_cap_zero: assert property (ACQ_BEGIN ##1 (RD_STB && ADDR[7:4] == PAGE_CAP)
        |-> ##1 RD_DATA == '0)
        else $error("capture not cleared by acquisition start");
    // Two reads of one capture with no scan between must agree
    a_cap_steady: assert property ((RD_STB && !SCAN_BEGIN_EVENT && !ACQ_BEGIN) ##1
        (RD_STB && $stable(ADDR) && ADDR[7:4] == PAGE_CAP && !SCAN_BEGIN_EVENT
        && !ACQ_BEGIN) |-> ##1 $stable(RD_DATA))
        else $error("capture changed without a scan");
    a_idx_fall_acq: assert property (($past(INDEX_FOUND) & ~INDEX_FOUND) != '0
        |-> $past(ACQ_BEGIN, 2))
        else $error("index flag dropped without acquisition start");
    a_cfg_readback: assert property ((WR_STB && ADDR[7:4] == PAGE_CFG
        && ADDR[1:0] == 2'h0) ##1 (RD_STB && $stable(ADDR))
        |-> ##1 RD_DATA == DATA_W'($past(WR_DATA[12:0], 2)))
        else $error("config readback mismatch");

    c_acq_scan: cover property (ACQ_BEGIN ##[1:300] SCAN_BEGIN_EVENT);
    c_idx_seen: cover property ($rose(INDEX_FOUND[0]));
    c_stat_rd: cover property ($past(RD_STB) && $past(ADDR) == OFS_STATUS);
endmodule

bind qesc_top qesc_top_props #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) qesc_top_props_i (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .COUNTER_INPUT_ZERO(COUNTER_INPUT_ZERO),
    .COUNTER_INPUT_ONE(COUNTER_INPUT_ONE), .COUNTER_INPUT_TWO(COUNTER_INPUT_TWO),
    .COUNTER_INPUT_THREE(COUNTER_INPUT_THREE), .SCAN_BEGIN_EVENT(SCAN_BEGIN_EVENT),
    .ACQ_BEGIN(ACQ_BEGIN), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .RD_DATA(RD_DATA), .INDEX_FOUND(INDEX_FOUND));

// ==== verif/tb.sv ====
`timescale 1ns/1ps

// ********************************************************************
// Self-checking bench
// ********************************************************************
module tb;
    import qesc_pkg::*;
    typedef struct {logic [1:0] res; bit up; logic [15:0] exp;} qesc_row_t;

    logic        clk = 1'b0, nrst = 1'b0, acq = 1'b0, scan = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0, rd_data;
    logic        wr_stb = 1'b0, rd_stb = 1'b0, ch3 = 1'b0;
    logic        step = 1'b0, dir_up = 1'b1, mark = 1'b0, glitch = 1'b0;
    logic        pha, phb, idxz;
    logic [3:0]  idx_found;
    int          fail_count = 0, checked = 0, cycles = 0;
    // Eight steps are two full quadrature cycles from any start phase
    qesc_row_t   rows [7] = '{'{2'h0, 1, 16'h0002}, '{2'h1, 1, 16'h0004},
        '{2'h2, 1, 16'h0008}, '{2'h3, 1, 16'h0008}, '{2'h0, 0, 16'hFFFE},
        '{2'h1, 0, 16'hFFFC}, '{2'h2, 0, 16'hFFF8}};

    always #25 clk = ~clk;

    // Phase A on the even pin, phase B on the next odd pin
    qesc_top qesc_top_i (.SYS_CLK(clk), .NRST(nrst), .COUNTER_INPUT_ZERO(pha),
        .COUNTER_INPUT_ONE(phb), .COUNTER_INPUT_TWO(idxz), .COUNTER_INPUT_THREE(ch3),
        .SCAN_BEGIN_EVENT(scan), .ACQ_BEGIN(acq), .ADDR(addr), .WR_DATA(wr_data),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .INDEX_FOUND(idx_found));
    qesc_enc_model qesc_enc_model_i (.clk(clk), .step(step), .dir_up(dir_up),
        .mark(mark), .glitch(glitch), .pha(pha), .phb(phb), .idx(idxz));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // Read data are valid only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk(nm, exp, rd_data);
    endtask

    task automatic ctl(input logic a, input logic s);
        @(posedge clk);
        acq <= a;
        scan <= s;
        @(posedge clk);
        acq <= 1'b0;
        scan <= 1'b0;
    endtask

    // Ten cycles per step leaves room for sync and short debounce
    task automatic steps(input int n, input bit up);
        repeat (n) begin
            @(posedge clk);
            step <= 1'b1;
            dir_up <= up;
            @(posedge clk);
            step <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask

    task automatic mark_pulse;
        @(posedge clk);
        mark <= 1'b1;
        repeat (10) @(posedge clk);
        mark <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    // Hang guard: whole run needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h00, 32'h0, "cfg0 reset");
        foreach (rows[i]) begin
            wr(8'h00, {28'h0, rows[i].res, 2'h1});
            ctl(1'b1, 1'b0);
            ctl(1'b0, 1'b1);
            rd(8'h10, 32'h0, "cap0 first scan");
            steps(8, rows[i].up);
            ctl(1'b0, 1'b1);
            steps(1, rows[i].up);
            rd(8'h10, {16'h0, rows[i].exp}, "cap0 count");
        end
        // Register bus corners
        rd(8'h24, 32'h0, "unmapped");
        rd(8'h01, 32'h0, "unaligned");
        wr(8'h10, 32'h1234);
        rd(8'h10, 32'h0000FFF8, "cap write ignored");
        // Two reads back to back see the same capture
        @(posedge clk);
        addr <= 8'h10;
        rd_stb <= 1'b1;
        @(posedge clk);
        #1;
        chk("cap read one", 32'h0000FFF8, rd_data);
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("cap read two", 32'h0000FFF8, rd_data);
        // Write then read with no gap between the strobes
        @(posedge clk);
        addr <= 8'h0C;
        wr_data <= 32'hFFFFFFFF;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("cfg3 fields", 32'h00001FFF, rd_data);
        wr(8'h0C, 32'h0);
        // Index clear on mapped channel two
        wr(8'h00, 32'h000000A9);
        ctl(1'b1, 1'b0);
        rd(8'h20, 32'h0, "status after acq");
        steps(4, 1);
        mark_pulse();
        #1;
        chk("index flag", 32'h1, {28'h0, idx_found});
        steps(3, 1);
        ctl(0, 1);
        rd(8'h10, 32'h3, "cap after index clear");
        // Gate from channel three
        wr(8'h00, 32'h00000079);
        ctl(1'b1, 1'b0);
        steps(4, 1);
        @(posedge clk);
        ch3 <= 1'b1;
        repeat (4) @(posedge clk);
        steps(4, 1);
        ctl(1'b0, 1'b1);
        rd(8'h10, 32'h4, "gated count");
        chk("index after acq", 32'h0, {28'h0, idx_found});
        // One-cycle vibration glitch under short debounce
        wr(8'h00, 32'h00000409);
        ctl(1'b1, 1'b0);
        @(posedge clk);
        glitch <= 1'b1;
        @(posedge clk);
        glitch <= 1'b0;
        steps(4, 1);
        ctl(1'b0, 1'b1);
        rd(8'h10, 32'h4, "debounced count");
        // Encoder on odd pin must not count, then period on phase B
        wr(8'h04, 32'h1);
        ctl(1'b1, 1'b0);
        steps(8, 1);
        ctl(1'b0, 1'b1);
        rd(8'h14, 32'h0, "odd encoder");
        wr(8'h04, 32'h2);
        ctl(1'b1, 1'b0);
        steps(12, 1);
        ctl(1'b0, 1'b1);
        rd(8'h14, 32'h28, "period ticks");
        // Coarser tick of four clocks: forty clocks give ten ticks
        wr(8'h04, 32'h102);
        ctl(1'b1, 1'b0);
        steps(12, 1);
        ctl(1'b0, 1'b1);
        rd(8'h14, 32'hA, "period coarse ticks");
        // Index crossings totalized
        wr(8'h08, 32'h0);
        ctl(1'b1, 1'b0);
        repeat (3) mark_pulse();
        ctl(1'b0, 1'b1);
        rd(8'h18, 32'h3, "index total");
        // Start and scan together: clear wins
        @(posedge clk);
        acq <= 1'b1;
        scan <= 1'b1;
        addr <= 8'h18;
        @(posedge clk);
        acq <= 1'b0;
        scan <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("acq with scan", 32'h0, rd_data);
        // Reset in mid-run
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h00, 32'h0, "cfg0 after reset");
        tally_and_finish();
    end
endmodule
